// File: shared/dcd_defs.svh
`ifndef DCD_DEFS_SVH
`define DCD_DEFS_SVH
// ----------------------------------------
// timing counts in clocks
// ----------------------------------------
`define DCD_CKE_HOLD_CLK    4'h3
`define DCD_XSRD_CLK       16'h00c8
`define DCD_XSNR_CLK       16'h00c8
`define DCD_XP_CLK         16'h0002
`define DCD_PD_MAX_CLK     16'h0100
// ----------------------------------------
// address field position and widths
// ----------------------------------------
`define DCD_AP_BIT         10
`define DCD_BA_W           3
`define DCD_ADDR_W         14
`endif

// File: shared/dcd_pkg.sv
`default_nettype none
package dcd_pkg;
  typedef enum logic [3:0] {
    DCD_OP_NOP  = 4'h0,
    DCD_OP_ACT  = 4'h1,
    DCD_OP_PRE  = 4'h2,
    DCD_OP_RD   = 4'h3,
    DCD_OP_WR   = 4'h4,
    DCD_OP_MRS  = 4'h5,
    DCD_OP_REF  = 4'h6,
    DCD_OP_PDN  = 4'h7,
    DCD_OP_SRF  = 4'h8,
    DCD_OP_WAKE = 4'h9
  } dcd_op_t;

  typedef enum logic [4:0] {
    DCD_ST_RUN  = 5'h01,
    DCD_ST_CKE  = 5'h02,
    DCD_ST_PD   = 5'h04,
    DCD_ST_SR   = 5'h08,
    DCD_ST_EXIT = 5'h10
  } dcd_state_t;

  typedef struct packed {
    dcd_op_t     op;
    logic        auto_pre;
    logic [2:0]  bank;
    logic [13:0] addr;
  } dcd_req_t;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [2:0]  ba;
    logic [13:0] a;
  } dcd_pins_t;

  typedef struct packed {
    dcd_state_t  st;
    dcd_pins_t   pins;
    logic        pins_oe;
    logic [7:0]  open_banks;
    logic [3:0]  cke_cnt;
    logic [15:0] wait_cnt;
    logic [15:0] rd_cnt;
    logic [15:0] res_cnt;
    logic        busy;
    logic        err;
  } dcd_state_s_t;
endpackage : dcd_pkg
`default_nettype wire

// File: src/dcd_ctrl.sv
`default_nettype none
`include "dcd_defs.svh"
module dcd_ctrl #(
  parameter int unsigned XSNR_CLK   = 200,
  parameter int unsigned XSRD_CLK   = 200,
  parameter int unsigned PD_MAX_CLK = 256,
  parameter int unsigned BUSY_CLK   = 4
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  input  wire logic              i_req_valid,
  input  wire dcd_pkg::dcd_req_t i_req,
  input  wire logic              i_odt_req,
  input  wire logic              i_calib,
  input  wire logic              i_wr_mask,
  output logic                   o_req_ready,
  output logic                   o_req_error,
  output dcd_pkg::dcd_pins_t     o_pins,
  output logic                   o_pins_oe,
  output logic                   o_odt,
  output logic                   o_dm,
  output logic                   o_power_down,
  output logic                   o_self_refresh
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (XSNR_CLK < 1 || XSNR_CLK > 65535 || XSRD_CLK < 1 || XSRD_CLK > 65535)
  begin : g_bad_exit
    $error("dcd_ctrl: exit counts out of range");
  end
  if (PD_MAX_CLK < 4 || PD_MAX_CLK > 65535)
  begin : g_bad_res
    $error("dcd_ctrl: residency count out of range");
  end
  if (BUSY_CLK < 1 || BUSY_CLK > 65535)
  begin : g_bad_busy
    $error("dcd_ctrl: busy count out of range");
  end

  // ----------------------------------------
  // counter loads
  // ----------------------------------------
  // the checks above keep every load inside the 16-bit counters
  localparam logic [15:0] XSNR_N = 16'(XSNR_CLK);
  localparam logic [15:0] XSRD_N = 16'(XSRD_CLK);
  localparam logic [15:0] PDMX_N = 16'(PD_MAX_CLK);
  localparam logic [15:0] BUSY_N = 16'(BUSY_CLK);

  dcd_pkg::dcd_state_s_t s_q;
  dcd_pkg::dcd_state_s_t s_d;

  // ----------------------------------------
  // pin pattern for one command
  // ----------------------------------------
  function automatic dcd_pkg::dcd_pins_t enc(input dcd_pkg::dcd_req_t r, input logic cke);
    dcd_pkg::dcd_pins_t p;
    p       = '0;
    p.cke   = cke;
    p.cs_n  = 1'b0;
    {p.ras_n, p.cas_n, p.we_n} = 3'h7;
    p.ba    = r.bank;
    p.a     = r.addr;
    case (r.op)
      dcd_pkg::DCD_OP_ACT: {p.ras_n, p.cas_n, p.we_n} = 3'h3;
      dcd_pkg::DCD_OP_PRE: {p.ras_n, p.cas_n, p.we_n} = 3'h2;
      dcd_pkg::DCD_OP_RD:  {p.ras_n, p.cas_n, p.we_n} = 3'h5;
      dcd_pkg::DCD_OP_WR:  {p.ras_n, p.cas_n, p.we_n} = 3'h4;
      dcd_pkg::DCD_OP_MRS: {p.ras_n, p.cas_n, p.we_n} = 3'h0;
      // refresh and self refresh entry share a pattern; cke tells them apart
      dcd_pkg::DCD_OP_REF: {p.ras_n, p.cas_n, p.we_n} = 3'h1;
      dcd_pkg::DCD_OP_SRF: {p.ras_n, p.cas_n, p.we_n} = 3'h1;
      default:             {p.ras_n, p.cas_n, p.we_n} = 3'h7;
    endcase
    if (r.op == dcd_pkg::DCD_OP_RD || r.op == dcd_pkg::DCD_OP_WR
        || r.op == dcd_pkg::DCD_OP_PRE)
      p.a[`DCD_AP_BIT] = r.auto_pre;
    return p;
  endfunction : enc

  // deselect drives address and bank to zero so nothing floats
  function automatic dcd_pkg::dcd_pins_t idle_pins(input logic cke);
    dcd_pkg::dcd_pins_t p;
    p      = '0;
    p.cke  = cke;
    p.cs_n = 1'b1;
    {p.ras_n, p.cas_n, p.we_n} = 3'h7;
    return p;
  endfunction : idle_pins

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic cke_held;
  logic acc;
  logic legal;
  dcd_pkg::dcd_op_t op;

  always_comb
  begin
    s_d      = s_q;
    op       = i_req.op;
    acc      = 1'b0;
    legal    = 1'b0;
    // three registered edges per CKE level
    cke_held = (s_q.cke_cnt >= `DCD_CKE_HOLD_CLK);
    s_d.pins = idle_pins(s_q.pins.cke);
    s_d.err  = 1'b0;
    if (s_q.cke_cnt < `DCD_CKE_HOLD_CLK)
      s_d.cke_cnt = s_q.cke_cnt + 4'h1;
    if (s_q.wait_cnt != 16'h0000)
      s_d.wait_cnt = s_q.wait_cnt - 16'h0001;
    if (s_q.rd_cnt != 16'h0000)
      s_d.rd_cnt = s_q.rd_cnt - 16'h0001;
    if (s_q.busy && s_q.res_cnt != 16'h0000)
      s_d.res_cnt = s_q.res_cnt - 16'h0001;
    if (s_q.res_cnt <= 16'h0001)
      s_d.busy = 1'b0;
    case (s_q.st)
      dcd_pkg::DCD_ST_RUN:
      begin
        // cke leaves reset low and rises under deselect only
        if (!s_q.pins.cke)
        begin
          s_d.pins     = idle_pins(1'b1);
          s_d.cke_cnt  = 4'h1;
          // first command waits out the exit latency
          s_d.wait_cnt = `DCD_XP_CLK;
        end
        // ready stays low while an exit interval runs
        else if (i_req_valid && s_q.wait_cnt == 16'h0000)
        begin
          // only legal commands while CKE high
          case (op)
            dcd_pkg::DCD_OP_NOP: legal = 1'b1;
            dcd_pkg::DCD_OP_ACT: legal = !s_q.open_banks[i_req.bank];
            // burst never cut short: next access waits
            dcd_pkg::DCD_OP_RD:  legal = s_q.open_banks[i_req.bank] && !s_q.busy
                                         && s_q.rd_cnt == 16'h0000;
            dcd_pkg::DCD_OP_WR:  legal = s_q.open_banks[i_req.bank] && !s_q.busy;
            dcd_pkg::DCD_OP_PRE: legal = !s_q.busy;
            dcd_pkg::DCD_OP_MRS: legal = s_q.open_banks == 8'h00 && !s_q.busy;
            dcd_pkg::DCD_OP_REF: legal = s_q.open_banks == 8'h00 && !s_q.busy;
            dcd_pkg::DCD_OP_PDN: legal = !s_q.busy && cke_held && !i_calib;
            // self refresh only from all banks idle
            dcd_pkg::DCD_OP_SRF: legal = !s_q.busy && cke_held && !i_calib
                                         && s_q.open_banks == 8'h00;
            default:             legal = 1'b0;
          endcase
          acc     = 1'b1;
          s_d.err = !legal;
          // refused requests leave the pins at deselect
          if (legal && op != dcd_pkg::DCD_OP_NOP)
          begin
            s_d.pins = enc(i_req, 1'b1);
            case (op)
              dcd_pkg::DCD_OP_ACT: s_d.open_banks[i_req.bank] = 1'b1;
              dcd_pkg::DCD_OP_PRE:
              begin
                if (i_req.auto_pre)
                  s_d.open_banks = 8'h00;
                else
                  s_d.open_banks[i_req.bank] = 1'b0;
              end
              dcd_pkg::DCD_OP_RD, dcd_pkg::DCD_OP_WR:
              begin
                if (i_req.auto_pre)
                  s_d.open_banks[i_req.bank] = 1'b0;
              end
              dcd_pkg::DCD_OP_PDN:
              begin
                s_d.pins    = idle_pins(1'b0);
                s_d.cke_cnt = 4'h1;
                s_d.res_cnt = PDMX_N;
                s_d.st      = dcd_pkg::DCD_ST_PD;
              end
              dcd_pkg::DCD_OP_SRF:
              begin
                s_d.pins.cke = 1'b0;
                s_d.cke_cnt  = 4'h1;
                s_d.st       = dcd_pkg::DCD_ST_SR;
              end
              default: ;
            endcase
            // busy spans every operation that bars cke from falling
            if (op != dcd_pkg::DCD_OP_ACT && op != dcd_pkg::DCD_OP_PDN
                && op != dcd_pkg::DCD_OP_SRF)
            begin
              s_d.busy    = 1'b1;
              s_d.res_cnt = BUSY_N;
            end
          end
        end
      end
      dcd_pkg::DCD_ST_PD:
      begin
        // wake waits until cke low is registered three times
        if (cke_held && ((i_req_valid && op == dcd_pkg::DCD_OP_WAKE)
                         || s_q.res_cnt == 16'h0000))
        begin
          acc         = i_req_valid && op == dcd_pkg::DCD_OP_WAKE;
          s_d.pins    = idle_pins(1'b1);
          s_d.cke_cnt = 4'h1;
          s_d.wait_cnt = `DCD_XP_CLK;
          s_d.st      = dcd_pkg::DCD_ST_RUN;
        end
        s_d.busy = 1'b0;
        if (s_q.res_cnt != 16'h0000)
          s_d.res_cnt = s_q.res_cnt - 16'h0001;
      end
      dcd_pkg::DCD_ST_SR:
      begin
        // no forced exit: the array refreshes itself here
        if (cke_held && i_req_valid && op == dcd_pkg::DCD_OP_WAKE)
        begin
          acc = 1'b1;
          s_d.pins     = idle_pins(1'b1);
          s_d.cke_cnt  = 4'h1;
          s_d.wait_cnt = XSNR_N;
          s_d.rd_cnt   = XSRD_N;
          s_d.st       = dcd_pkg::DCD_ST_RUN;
        end
      end
      default: s_d.st = dcd_pkg::DCD_ST_RUN;
    endcase
    // a refused request never leaks its pattern to the pins
    if (acc && s_d.err)
      s_d.pins = idle_pins(s_q.pins.cke);
    s_d.pins_oe = 1'b1;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s_q         <= '0;
      s_q.st      <= dcd_pkg::DCD_ST_RUN;
      s_q.pins    <= '0;
      s_q.pins.cs_n  <= 1'b1;
      s_q.pins.ras_n <= 1'b1;
      s_q.pins.cas_n <= 1'b1;
      s_q.pins.we_n  <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_req_ready    = acc;
  assign o_req_error    = s_q.err;
  assign o_pins         = s_q.pins;
  // oe rises on the first edge after reset and stays up
  assign o_pins_oe      = s_q.pins_oe;
  // odt always at a defined level
  assign o_odt          = i_odt_req && s_q.st != dcd_pkg::DCD_ST_SR;
  assign o_dm           = i_wr_mask;
  assign o_power_down   = s_q.st == dcd_pkg::DCD_ST_PD;
  assign o_self_refresh = s_q.st == dcd_pkg::DCD_ST_SR;
endmodule : dcd_ctrl
`default_nettype wire

// File: test/dcd_ctrl_monitor.sv
`default_nettype none
module dcd_ctrl_monitor #(
  parameter int unsigned XSNR_CLK   = 200,
  parameter int unsigned XSRD_CLK   = 200,
  parameter int unsigned PD_MAX_CLK = 256
) (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic               i_calib,
  input  wire logic               i_wr_mask,
  input  wire dcd_pkg::dcd_pins_t o_pins,
  input  wire logic               o_odt,
  input  wire logic               o_dm,
  input  wire logic               o_power_down,
  input  wire logic               o_self_refresh
);
  logic        cmd;
  logic        rd;
  int unsigned pd_q;
  int unsigned x_q;
  assign cmd = !o_pins.cs_n && !(o_pins.ras_n && o_pins.cas_n && o_pins.we_n);
  assign rd  = cmd && o_pins.ras_n && !o_pins.cas_n && o_pins.we_n;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------
  // residency and exit counters
  // ----------------------------------------
  // x_q saturates so a long run never wraps into a false gap
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pd_q <= 0;
      x_q  <= 1000;
    end
    else
    begin
      pd_q <= o_power_down ? pd_q + 1 : 0;
      x_q  <= o_self_refresh ? 0 : (x_q < 1000 ? x_q + 1 : x_q);
    end
  end
  a_cke_low_hold: assert property ($fell(o_pins.cke) |-> !o_pins.cke [*3])
    else $error("cke low not held three edges");
  a_cke_high_hold: assert property ($rose(o_pins.cke) |-> o_pins.cke [*3])
    else $error("cke high not held three edges");
  a_entry_nop_ref: assert property ($fell(o_pins.cke) |->
    !cmd || (!o_pins.ras_n && !o_pins.cas_n && o_pins.we_n))
    else $error("cke fell with a bad command");
  a_exit_only_nop: assert property ($rose(o_pins.cke) &&
    ($past(o_power_down) || $past(o_self_refresh)) |-> !cmd)
    else $error("cke rose with a command");
  a_low_no_cmd: assert property (!o_pins.cke && !$past(o_pins.cke) |-> !cmd)
    else $error("command while cke low");
  a_odt_off_sr: assert property (o_self_refresh |-> !o_odt)
    else $error("odt on in self refresh");
  a_dm_follow: assert property (o_dm == i_wr_mask)
    else $error("dm differs from mask");
  a_calib_cke_high: assert property (i_calib && o_pins.cke |=> o_pins.cke)
    else $error("cke dropped in calibration");
  a_pd_bounded: assert property (pd_q <= PD_MAX_CLK + 4)
    else $error("power-down too long");
  a_xsnr_gap: assert property (cmd && o_pins.cke && !o_self_refresh |->
    x_q + 2 >= XSNR_CLK)
    else $error("command too soon after exit");
  a_xsrd_gap: assert property (rd |-> x_q + 2 >= XSRD_CLK)
    else $error("read too soon after exit");
  c_pd_entry: cover property ($rose(o_power_down));
  c_sr_entry: cover property ($rose(o_self_refresh));
  c_read: cover property (rd);
endmodule : dcd_ctrl_monitor
bind dcd_ctrl dcd_ctrl_monitor #(
  .XSNR_CLK(XSNR_CLK), .XSRD_CLK(XSRD_CLK), .PD_MAX_CLK(PD_MAX_CLK)
) dcd_ctrl_monitor_inst (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_calib(i_calib), .i_wr_mask(i_wr_mask),
  .o_pins(o_pins), .o_odt(o_odt), .o_dm(o_dm), .o_power_down(o_power_down),
  .o_self_refresh(o_self_refresh)
);
`default_nettype wire

// File: test/dcd_dram_model.sv
`default_nettype none
module dcd_dram_model (
  input  wire logic               i_clk,
  input  wire dcd_pkg::dcd_pins_t i_pins,
  input  wire logic               i_oe,
  output logic [7:0]              o_banks,
  output logic [2:0]              o_mr_sel,
  output logic [1:0]              o_mode,
  output logic [7:0]              o_bad
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cke_n1;
  logic [3:0] c;
  assign c = {i_pins.cs_n, i_pins.ras_n, i_pins.cas_n, i_pins.we_n};
  // no reset pin on the device: power-up values only
  initial
  begin
    {cke_n1, o_banks, o_mr_sel, o_mode, o_bad} = '0;
  end
  // sampled at clock rise against prior cke
  // odt is not an input, so it cannot steer transitions
  always @(posedge i_clk)
  begin
    cke_n1 <= i_pins.cke;
    if (i_oe && cke_n1 && !i_pins.cke)
      o_mode <= (c == 4'h1) ? 2'h3 : (o_banks != 8'h00 ? 2'h2 : 2'h1);
    // any cke rise leaves the low-power mode
    else if (i_oe && !cke_n1 && i_pins.cke)
      o_mode <= 2'h0;
    // decode only with cke high twice
    else if (i_oe && cke_n1 && i_pins.cke && !i_pins.cs_n)
      case (c[2:0])
        3'h3: o_banks[i_pins.ba] <= 1'b1;
        3'h2: o_banks <= i_pins.a[10] ? 8'h00 : o_banks & ~(8'h01 << i_pins.ba);
        3'h5, 3'h4:
        begin
          if (!o_banks[i_pins.ba])
            o_bad <= o_bad + 8'h01;
          if (i_pins.a[10])
            o_banks[i_pins.ba] <= 1'b0;
        end
        3'h0: o_mr_sel <= i_pins.ba;
        default: ;
      endcase
  end
endmodule : dcd_dram_model
`default_nettype wire

// File: test/test_ddr2_command_and_cke_decoder.sv
`default_nettype none
module test_ddr2_command_and_cke_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_resetn = 1'b0, i_req_valid = 1'b0;
  logic i_odt_req = 1'b0, i_calib = 1'b0, i_wr_mask = 1'b0;
  logic o_req_ready, o_req_error, o_pins_oe, o_odt, o_dm, o_power_down, o_self_refresh;
  dcd_pkg::dcd_req_t  i_req = '0;
  dcd_pkg::dcd_pins_t o_pins;
  logic [7:0] banks, bad;
  logic [2:0] mr_sel;
  logic [1:0] mode;
  int n_mismatch = 0, num_checks = 0;
  always #4 i_clk = ~i_clk;
  dcd_ctrl #(.XSNR_CLK(8), .XSRD_CLK(8), .PD_MAX_CLK(16), .BUSY_CLK(2)) dcd_ctrl_inst (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_req_valid(i_req_valid), .i_req(i_req),
    .i_odt_req(i_odt_req), .i_calib(i_calib), .i_wr_mask(i_wr_mask),
    .o_req_ready(o_req_ready), .o_req_error(o_req_error), .o_pins(o_pins),
    .o_pins_oe(o_pins_oe), .o_odt(o_odt), .o_dm(o_dm), .o_power_down(o_power_down),
    .o_self_refresh(o_self_refresh));
  dcd_dram_model dcd_dram_model_inst (.i_clk(i_clk), .i_pins(o_pins), .i_oe(o_pins_oe),
    .o_banks(banks), .o_mr_sel(mr_sel), .o_mode(mode), .o_bad(bad));
  task automatic chkv(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chkv
  task automatic chk1(input logic g, input logic e);
    chkv({15'h0000, g}, {15'h0000, e});
  endtask : chk1
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // held until the edge where ready is high, then released
  task automatic issue(input dcd_pkg::dcd_op_t op, input logic [2:0] bk, input logic ap,
                       input logic [13:0] ad);
    int n;
    n = 0;
    @(posedge i_clk);
    i_req_valid <= 1'b1;
    i_req       <= '{op, ap, bk, ad};
    @(negedge i_clk);
    while (o_req_ready !== 1'b1 && n < 50)
    begin
      @(negedge i_clk);
      n++;
    end
    chk1(n < 50, 1'b1);
    @(posedge i_clk);
    i_req_valid <= 1'b0;
    @(negedge i_clk);
  endtask : issue
  task automatic cmd_ok(input dcd_pkg::dcd_op_t op, input logic [2:0] bk, input logic ap,
                        input logic [13:0] ad, input logic [3:0] enc);
    issue(op, bk, ap, ad);
    chkv({12'h000, o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n}, {12'h000, enc});
    chkv({13'h0000, o_pins.ba}, {13'h0000, bk});
    if (enc[2:0] != 3'h3 && enc[2:0] != 3'h0)
      chk1(o_pins.a[10], ap);
    else
      chkv({2'h0, o_pins.a}, {2'h0, ad});
    repeat (4) @(negedge i_clk);
  endtask : cmd_ok
  task automatic t_access();
    issue(dcd_pkg::DCD_OP_NOP, 3'h0, 1'b0, 14'h0000);
    repeat (4) @(negedge i_clk);
    cmd_ok(dcd_pkg::DCD_OP_ACT, 3'h3, 1'b0, 14'h0123, 4'h3);
    cmd_ok(dcd_pkg::DCD_OP_WR, 3'h3, 1'b0, 14'h0010, 4'h4);
    chkv({8'h00, banks}, 16'h0008);
    cmd_ok(dcd_pkg::DCD_OP_RD, 3'h3, 1'b1, 14'h0020, 4'h5);
    chkv({8'h00, banks}, 16'h0000);
    @(posedge i_clk);
    i_wr_mask <= 1'b1;
    @(negedge i_clk);
    chk1(o_dm, 1'b1);
    chk1(o_pins_oe, 1'b1);
    @(posedge i_clk);
    i_wr_mask <= 1'b0;
    @(negedge i_clk);
    chk1(o_dm, 1'b0);
  endtask : t_access
  task automatic t_mode();
    cmd_ok(dcd_pkg::DCD_OP_MRS, 3'h1, 1'b0, 14'h0044, 4'h0);
    chkv({13'h0000, mr_sel}, 16'h0001);
    cmd_ok(dcd_pkg::DCD_OP_ACT, 3'h5, 1'b0, 14'h0200, 4'h3);
    cmd_ok(dcd_pkg::DCD_OP_PRE, 3'h0, 1'b1, 14'h0000, 4'h2);
    chkv({8'h00, banks}, 16'h0000);
    issue(dcd_pkg::DCD_OP_RD, 3'h2, 1'b0, 14'h0000);
    chk1(o_req_error, 1'b1);
    chk1(o_pins.cs_n, 1'b1);
    repeat (4) @(negedge i_clk);
  endtask : t_mode
  task automatic t_power();
    @(posedge i_clk);
    i_calib <= 1'b1;
    issue(dcd_pkg::DCD_OP_PDN, 3'h0, 1'b0, 14'h0000);
    chk1(o_req_error, 1'b1);
    chk1(o_pins.cke, 1'b1);
    @(posedge i_clk);
    i_calib <= 1'b0;
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
        cmd_ok(dcd_pkg::DCD_OP_ACT, 3'h6, 1'b0, 14'h0001, 4'h3);
      repeat (4) @(negedge i_clk);
      issue(dcd_pkg::DCD_OP_PDN, 3'h0, 1'b0, 14'h0000);
      @(negedge i_clk);
      chk1(o_power_down, 1'b1);
      chkv({14'h0000, mode}, {14'h0000, 2'h1 + 2'(k)});
      repeat (3) @(negedge i_clk);
      issue(dcd_pkg::DCD_OP_WAKE, 3'h0, 1'b0, 14'h0000);
      repeat (4) @(negedge i_clk);
      chk1(o_power_down, 1'b0);
    end
    cmd_ok(dcd_pkg::DCD_OP_PRE, 3'h0, 1'b1, 14'h0000, 4'h2);
  endtask : t_power
  task automatic t_selfref();
    @(posedge i_clk);
    i_odt_req <= 1'b1;
    issue(dcd_pkg::DCD_OP_REF, 3'h0, 1'b0, 14'h0000);
    issue(dcd_pkg::DCD_OP_PDN, 3'h0, 1'b0, 14'h0000);
    chk1(o_req_error, 1'b1);
    repeat (4) @(negedge i_clk);
    cmd_ok(dcd_pkg::DCD_OP_REF, 3'h0, 1'b0, 14'h0000, 4'h1);
    issue(dcd_pkg::DCD_OP_SRF, 3'h0, 1'b0, 14'h0000);
    chk1(o_pins.cke, 1'b0);
    @(negedge i_clk);
    chk1(o_self_refresh, 1'b1);
    chk1(o_odt, 1'b0);
    chkv({14'h0000, mode}, 16'h0003);
    repeat (3) @(negedge i_clk);
    issue(dcd_pkg::DCD_OP_WAKE, 3'h0, 1'b0, 14'h0000);
    repeat (3) @(negedge i_clk);
    chk1(o_self_refresh, 1'b0);
    chk1(o_odt, 1'b1);
    cmd_ok(dcd_pkg::DCD_OP_ACT, 3'h1, 1'b0, 14'h0002, 4'h3);
    cmd_ok(dcd_pkg::DCD_OP_RD, 3'h1, 1'b0, 14'h0004, 4'h5);
    chkv({8'h00, bad}, 16'h0000);
  endtask : t_selfref
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_access();
    t_mode();
    t_power();
    t_selfref();
    close_out();
  end
  // the sequence needs well under a thousand cycles
  initial
  begin
    #40000;
    n_mismatch++;
    close_out();
  end
endmodule : test_ddr2_command_and_cke_decoder
`default_nettype wire
